/* logic/adc_clock_and_stop_control.sv */
// Converter clock generation, scan start alignment and halt handling
`timescale 1ns/1ps
module adc_clock_and_stop_control
    import adc_clock_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_osc_tick,
    input wire logic [1:0] i_scan_sync_input,
    input wire logic [1:0] i_scan_done,
    input wire logic [1:0] i_core_valid,
    input wire logic [1:0][RESULT_W-1:0] i_core_data,
    output logic o_conv_clock,
    output logic [1:0] o_scan_start,
    output logic [1:0] o_core_halt,
    output logic [1:0] o_core_power,
    output logic o_standby_current,
    output logic [1:0] o_sample_valid,
    output logic [1:0][RESULT_W-1:0] o_sample_data
);
    // Software-visible state
    logic [1:0] halt_request_bit_q;
    scan_mode_t scan_mode_q;
    logic simultaneous_flag_q;
    logic [DIV_W-1:0] divisor_q;
    logic [1:0] power_down_q;
    logic auto_powerdown_enable_q;
    logic auto_standby_enable_q;
    logic [DELAY_W-1:0] powerup_delay_field_q;
    logic [1:0][RESULT_W-1:0] conversion_result_reg_q;

    // Sequencing state
    conv_state_t state_q [2];
    conv_state_t state_d [2];
    logic [DELAY_W-1:0] wait_q [2];
    logic [DELAY_W-1:0] wait_d [2];
    logic [1:0] start_d;
    logic [DELAY_W-1:0] pu_cnt_q [2];
    logic [1:0] pu_busy_q;

    // Bus decode
    wire setup = i_psel & ~i_penable;
    wire access = i_psel & i_penable & o_pready;
    wire wr = access & i_pwrite;
    wire hit_ctl1 = (i_paddr == OFF_CONTROL1);
    wire hit_ctl2 = (i_paddr == OFF_CONTROL2);
    wire hit_pwr = (i_paddr == OFF_POWER);
    wire hit_sts = (i_paddr == OFF_STATUS);
    wire hit_res0 = (i_paddr == OFF_RESULT0);
    wire hit_res1 = (i_paddr == OFF_RESULT1);
    wire mapped = hit_ctl1 | hit_ctl2 | hit_pwr | hit_sts | hit_res0 |
        hit_res1;
    wire wr_ctl1 = wr & hit_ctl1;
    wire wr_ctl2 = wr & hit_ctl2;
    wire wr_pwr = wr & hit_pwr;
    wire [1:0] wr_res = {wr & hit_res1, wr & hit_res0};

    // Power and scan mode decode
    wire normal_mode = ~auto_powerdown_enable_q & ~auto_standby_enable_q;
    wire standby_mode = auto_standby_enable_q & ~auto_powerdown_enable_q;
    wire low_power = ~normal_mode;
    wire loop_mode = (scan_mode_q == SCAN_SEQ_LOOP) |
        (scan_mode_q == SCAN_PAR_LOOP);
    wire shared_start = (scan_mode_q == SCAN_SEQ_ONCE) |
        (scan_mode_q == SCAN_SEQ_LOOP) | simultaneous_flag_q;

    // Start sources
    wire [1:0] trig_wr = {2{wr_ctl1}} & i_pwdata[CTL_TRIG_LSB +: 2];
    wire [1:0] raw_trig = trig_wr | i_scan_sync_input;
    // One start event drives both converters unless parallel and not
    // simultaneous, where each converter has its own
    wire [1:0] trig_src = shared_start ? {2{raw_trig[0]}} : raw_trig; // see RQ15 see RQ16
    wire [1:0] idle_now = {state_q[1] == ST_IDLE, state_q[0] == ST_IDLE};
    // Halted or powering converters drop their starts silently
    wire [1:0] trig_ok = trig_src & ~halt_request_bit_q & idle_now &
        ~power_down_q & ~pu_busy_q; // see RQ2
    wire any_active = ~&idle_now;
    // Only a start that finds the block idle realigns the clock phase;
    // a later start waits for the next rising edge instead
    wire restart = (|trig_ok) & ~any_active; // see RQ14 see RQ17 see RQ18

    // Conversion clock
    wire [7:0] conv_half = 8'(CONV_HALF_UNIT * (int'(divisor_q) + 1)); // see RQ7 see RQ13
    wire clk_run = any_active | loop_mode | normal_mode | (|pu_busy_q); // see RQ5 see RQ8 see RQ9 see RQ10
    wire conv_level;
    wire conv_rise;
    wire stby_level;
    wire sel_standby = standby_mode & ~any_active & ~(|pu_busy_q); // see RQ12 see RQ20

    // The divider keeps ticking until its level is low, so stopping the
    // clock never leaves a short high pulse behind
    clk_divider #(.W(8)) u_conv_div (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_tick(clk_run | conv_level),
        .i_restart(restart),
        .i_half(conv_half),
        .o_level(conv_level),
        .o_rise(conv_rise)
    );

    clk_divider #(.W(8)) u_stby_div (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_tick(i_osc_tick),
        .i_restart(1'b0),
        .i_half(STANDBY_HALF), // see RQ11
        .o_level(stby_level),
        .o_rise()
    );

    clk_switch u_switch (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_sel_alt(sel_standby),
        .i_main(conv_level),
        .i_alt(stby_level),
        .o_clk(o_conv_clock)
    );

    // Per-converter scan sequencing
    always_comb begin
        for (int n = 0; n < 2; n++) begin
            state_d[n] = state_q[n];
            wait_d[n] = wait_q[n];
            start_d[n] = 1'b0;
            if (halt_request_bit_q[n]) begin
                // Stay idle until a fresh start after the halt clears
                state_d[n] = ST_IDLE; // see RQ1 see RQ23
            end else begin
                unique case (state_q[n])
                    ST_IDLE: begin
                        if (trig_ok[n] && low_power) begin
                            state_d[n] = ST_POWERUP; // see RQ19
                            wait_d[n] = powerup_delay_field_q;
                        end else if (trig_ok[n]) begin
                            state_d[n] = ST_ALIGN;
                        end
                    end
                    ST_POWERUP: begin
                        if (conv_rise && wait_q[n] <= DELAY_W'(1)) begin
                            state_d[n] = ST_ALIGN;
                        end else if (conv_rise) begin
                            wait_d[n] = wait_q[n] - DELAY_W'(1);
                        end
                    end
                    ST_ALIGN: begin
                        if (conv_rise) begin
                            state_d[n] = ST_RUN; // see RQ17
                            start_d[n] = 1'b1;
                        end
                    end
                    ST_RUN: begin
                        if (i_scan_done[n] && !loop_mode) begin
                            state_d[n] = ST_IDLE; // see RQ10
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int n = 0; n < 2; n++) begin
                state_q[n] <= ST_IDLE;
                wait_q[n] <= '0;
            end
            o_scan_start <= 2'h0;
            o_core_halt <= 2'h0;
        end else begin
            for (int n = 0; n < 2; n++) begin
                state_q[n] <= state_d[n];
                wait_q[n] <= wait_d[n];
            end
            o_scan_start <= start_d;
            o_core_halt <= halt_request_bit_q; // see RQ1
        end
    end

    // Power-up delay after a power-down bit is cleared
    wire [1:0] pd_new = i_pwdata[PWR_DOWN_LSB +: 2];
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int n = 0; n < 2; n++) begin
                pu_cnt_q[n] <= '0;
            end
            pu_busy_q <= 2'h0;
        end else begin
            for (int n = 0; n < 2; n++) begin
                if (wr_pwr && power_down_q[n] && !pd_new[n]) begin
                    pu_cnt_q[n] <= powerup_delay_field_q; // see RQ9
                    pu_busy_q[n] <= (powerup_delay_field_q != '0);
                end else if (pu_busy_q[n] && conv_rise) begin
                    pu_cnt_q[n] <= pu_cnt_q[n] - DELAY_W'(1);
                    pu_busy_q[n] <= (pu_cnt_q[n] > DELAY_W'(1));
                end
            end
        end
    end

    // Control registers
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            halt_request_bit_q <= 2'h0;
            scan_mode_q <= SCAN_SEQ_ONCE;
            simultaneous_flag_q <= 1'b0;
            divisor_q <= DIV_RST;
        end else begin
            if (wr_ctl1) begin
                halt_request_bit_q <= i_pwdata[CTL_HALT_LSB +: 2];
                scan_mode_q <= scan_mode_t'(i_pwdata[CTL_MODE_LSB +: 2]);
                simultaneous_flag_q <= i_pwdata[CTL_SIMULTANEOUS_FLAG_BIT];
            end
            if (wr_ctl2) begin
                divisor_q <= i_pwdata[DIV_W-1:0]; // see RQ7
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            power_down_q <= PWR_DOWN_RST;
            auto_powerdown_enable_q <= 1'b0;
            auto_standby_enable_q <= 1'b0;
            powerup_delay_field_q <= DELAY_RST;
        end else if (wr_pwr) begin
            power_down_q <= pd_new;
            auto_powerdown_enable_q <= i_pwdata[PWR_APD_BIT];
            auto_standby_enable_q <= i_pwdata[PWR_ASB_BIT]; // see RQ20 see RQ21
            powerup_delay_field_q <= i_pwdata[PWR_DELAY_LSB +: DELAY_W];
        end
    end

    // Result registers: core samples normally, software writes when halted
    wire [1:0] sw_sample = wr_res & halt_request_bit_q; // see RQ3
    wire [1:0] hw_sample = i_core_valid & ~halt_request_bit_q;
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            conversion_result_reg_q <= '0;
            o_sample_valid <= 2'h0;
            o_sample_data <= '0;
        end else begin
            for (int n = 0; n < 2; n++) begin
                // A halted-mode write goes out exactly like a core sample
                if (sw_sample[n]) begin
                    conversion_result_reg_q[n] <= i_pwdata[RESULT_W-1:0]; // see RQ3
                    o_sample_data[n] <= i_pwdata[RESULT_W-1:0]; // see RQ4
                end else if (hw_sample[n]) begin
                    conversion_result_reg_q[n] <= i_core_data[n];
                    o_sample_data[n] <= i_core_data[n];
                end
            end
            o_sample_valid <= sw_sample | hw_sample; // see RQ4
        end
    end

    // Core-facing power levels
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_core_power <= 2'h0;
            o_standby_current <= 1'b0;
        end else begin
            for (int n = 0; n < 2; n++) begin
                o_core_power[n] <= ~power_down_q[n] &
                    (~auto_powerdown_enable_q | ~idle_now[n]);
            end
            o_standby_current <= sel_standby;
        end
    end

    // Read data
    wire [31:0] rd_ctl1 = 32'({simultaneous_flag_q, scan_mode_q, 2'h0,
        halt_request_bit_q});
    wire [31:0] rd_ctl2 = 32'(divisor_q);
    wire [31:0] rd_pwr = 32'({pu_busy_q, powerup_delay_field_q,
        auto_standby_enable_q, auto_powerdown_enable_q, power_down_q});
    wire [31:0] rd_sts = 32'({sel_standby, ~idle_now});
    wire [31:0] rd_res0 = 32'(conversion_result_reg_q[0]);
    wire [31:0] rd_res1 = 32'(conversion_result_reg_q[1]);
    wire [31:0] rd_data = hit_ctl1 ? rd_ctl1 :
        hit_ctl2 ? rd_ctl2 :
        hit_pwr ? rd_pwr :
        hit_sts ? rd_sts :
        hit_res0 ? rd_res0 :
        hit_res1 ? rd_res1 : 32'h00000000;

    // One wait-free access cycle: answer is prepared during setup so the
    // bus outputs can come straight from flip-flops
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h00000000;
        end else begin
            o_pready <= setup;
            o_pslverr <= setup & ~mapped;
            o_prdata <= (setup & ~i_pwrite) ? rd_data : 32'h00000000;
        end
    end
endmodule : adc_clock_and_stop_control

/* logic/adc_clock_pkg.sv */
// Constants and types for the converter clock and stop control block
// Operation
// RQ1: Setting a converter's halt bit aborts its scan in progress.
// RQ2: While halted, sync pulses and start-bit writes to it are ignored.
// RQ3: While halted, software may write that converter's result register.
// RQ4: Such a write is passed on like a core sample to the checks.
// RQ5: Any scan in process always runs on the conversion clock.
// RQ6: Software keeps the conversion clock between 100 kHz and 5 MHz.
// RQ7: Conversion clock is the bus clock divided per the divisor field.
// RQ8: Clock runs nonstop in looping scan modes or normal power mode.
// RQ9: Clock runs through converter power-up for the delay field count.
// RQ10: In auto modes the clock runs on until the scan completes.
// RQ11: Standby clock is the oscillator divided by eighty.
// RQ12: Standby clock is used only in auto standby with both idle.
// RQ13: Fastest converter clock period is six system clocks.
// RQ14: A scan start restarts the converter clock phase at once.
// RQ15: Sequential and simultaneous modes share one start event.
// RQ16: Non-simultaneous parallel mode starts each converter on its own.
// RQ17: Only the first starter is aligned; the later waits for an edge.
// RQ18: Which converter is aligned follows start order, not a fixed one.
// RQ19: Low-power modes wait the delay field count before each scan.
// RQ20: Auto standby when standby enable set and auto power-down clear.
// RQ21: Normal mode when auto power-down and auto standby are clear.
// RQ22: Switching clock sources never truncates or glitches a pulse.
// RQ23: Clearing a halt bit does not start a scan by itself.
package adc_clock_pkg;
    localparam logic [7:0] OFF_CONTROL1 = 8'h00;
    localparam logic [7:0] OFF_CONTROL2 = 8'h04;
    localparam logic [7:0] OFF_POWER = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_RESULT0 = 8'h10;
    localparam logic [7:0] OFF_RESULT1 = 8'h14;
    localparam int CTL_HALT_LSB = 0;
    localparam int CTL_TRIG_LSB = 2;
    localparam int CTL_MODE_LSB = 4;
    localparam int CTL_SIMULTANEOUS_FLAG_BIT = 6;
    localparam int PWR_DOWN_LSB = 0;
    localparam int PWR_APD_BIT = 2;
    localparam int PWR_ASB_BIT = 3;
    localparam int PWR_DELAY_LSB = 4;
    localparam int PWR_STS_LSB = 10;
    localparam int STS_BUSY_LSB = 0;
    localparam int STS_STBY_BIT = 2;
    localparam int DIV_W = 5;
    localparam int DELAY_W = 6;
    localparam int RESULT_W = 12;
    localparam logic [1:0] PWR_DOWN_RST = 2'h3;
    localparam logic [DELAY_W-1:0] DELAY_RST = 6'h0D;
    localparam logic [DIV_W-1:0] DIV_RST = 5'h00;
    localparam int MIN_CONV_PERIOD = 6;
    localparam int CONV_HALF_UNIT = MIN_CONV_PERIOD / 2;
    localparam int STANDBY_DIVIDE = 80;
    localparam logic [7:0] STANDBY_HALF = 8'(STANDBY_DIVIDE / 2);
    typedef enum logic [1:0] {
        SCAN_SEQ_ONCE, SCAN_PAR_ONCE, SCAN_SEQ_LOOP, SCAN_PAR_LOOP
    } scan_mode_t;
    typedef enum logic [1:0] {
        ST_IDLE, ST_POWERUP, ST_ALIGN, ST_RUN
    } conv_state_t;
endpackage : adc_clock_pkg

/* logic/clk_divider.sv */
// Restartable divider producing a clock level and a rise pulse
`timescale 1ns/1ps
module clk_divider #(
    parameter int W = 8
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_tick,
    input wire logic i_restart,
    input wire logic [W-1:0] i_half,
    output logic o_level,
    output logic o_rise
);
    logic [W-1:0] cnt_q;
    wire at_half = (cnt_q >= i_half - W'(1));
    wire toggle = i_tick & at_half;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q <= '0;
            o_level <= 1'b0;
            o_rise <= 1'b0;
        end else if (i_restart) begin
            // Phase restart: a fresh high half starts on this edge
            cnt_q <= '0;
            o_level <= 1'b1;
            o_rise <= 1'b1;
        end else begin
            o_rise <= toggle & ~o_level;
            if (toggle) begin
                cnt_q <= '0;
                o_level <= ~o_level;
            end else if (i_tick) begin
                cnt_q <= cnt_q + W'(1);
            end
        end
    end
endmodule : clk_divider

/* logic/clk_switch.sv */
// Glitch-free selection between two clock levels
`timescale 1ns/1ps
module clk_switch (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_sel_alt,
    input wire logic i_main,
    input wire logic i_alt,
    output logic o_clk
);
    logic sel_q;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            sel_q <= 1'b0;
            o_clk <= 1'b0;
        end else begin
            // Swap only while both sources are low so no pulse is cut
            if (!i_main && !i_alt) begin
                sel_q <= i_sel_alt; // see RQ22
            end
            o_clk <= sel_q ? i_alt : i_main;
        end
    end
endmodule : clk_switch

/* verification/adc_clock_and_stop_control_properties.sv */
// Port-level checks for the converter clock and halt control block
`timescale 1ns/1ps
module adc_clock_and_stop_control_properties
    import adc_clock_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_conv_clock,
    input wire logic [1:0] o_scan_start,
    input wire logic [1:0] o_core_halt,
    input wire logic o_standby_current,
    input wire logic [1:0] o_sample_valid,
    input wire logic [1:0][RESULT_W-1:0] o_sample_data
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    wire wr_acc = i_psel && i_penable && i_pwrite && o_pready;
    wire wr_ctl = wr_acc && i_paddr == OFF_CONTROL1;
    wire wr_res = wr_acc && i_paddr == OFF_RESULT0 && o_core_halt[0];
    a_halt_visible: assert property ( // halt
        wr_ctl |=> ##1 o_core_halt == $past(i_pwdata[1:0], 2))
        else $error("halt outputs do not follow control write");
    a_halt_blocks_a: assert property ( // held halt
        o_core_halt[0] [*3] |-> !o_scan_start[0])
        else $error("converter 0 started while halted");
    a_halt_blocks_b: assert property ( // held halt
        o_core_halt[1] [*3] |-> !o_scan_start[1])
        else $error("converter 1 started while halted");
    a_result_pulse: assert property ( // written sample
        wr_res |=> o_sample_valid[0])
        else $error("halted result write gave no sample pulse");
    a_result_data: assert property ( // written data
        wr_res |=> o_sample_data[0] == $past(i_pwdata[RESULT_W-1:0]))
        else $error("halted result write gave wrong sample data");
    a_scan_conv_clock: assert property ( // source
        o_scan_start != 2'b00 |-> !o_standby_current)
        else $error("scan started on the standby clock");
    a_conv_high_min: assert property ( // pulse width
        $rose(o_conv_clock) |-> o_conv_clock [*3])
        else $error("converter clock high phase too short");
    a_start_single: assert property ( // start pulse
        o_scan_start[0] |=> !o_scan_start[0])
        else $error("scan start pulse longer than one cycle");
    a_error_with_ready: assert property (
        o_pslverr |-> o_pready)
        else $error("slave error without ready");
    c_shared: cover property (o_scan_start == 2'b11);
    c_own: cover property (o_scan_start == 2'b10);
    c_standby: cover property ($rose(o_standby_current));
endmodule : adc_clock_and_stop_control_properties

bind adc_clock_and_stop_control adc_clock_and_stop_control_properties
    props_inst (.i_clock, .i_rstn, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .o_conv_clock,
    .o_scan_start, .o_core_halt, .o_standby_current, .o_sample_valid,
    .o_sample_data);

/* verification/converter_core_model.sv */
// Behavioural analog core: samples on converter clock rises after a start
`timescale 1ns/1ps
module converter_core_model
    import adc_clock_pkg::*;
#(
    parameter int SAMPLES = 2
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_conv_clock,
    input wire logic [1:0] i_scan_start,
    input wire logic [1:0] i_core_halt,
    output logic [1:0] o_core_valid,
    output logic [1:0][RESULT_W-1:0] o_core_data,
    output logic [1:0] o_scan_done
);
    logic conv_q;
    logic [1:0] busy_q;
    int left_q [2];
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            conv_q <= 1'b0;
            busy_q <= 2'b00;
            o_core_valid <= 2'b00;
            o_scan_done <= 2'b00;
            o_core_data <= '0;
        end else begin
            conv_q <= i_conv_clock;
            for (int n = 0; n < 2; n++) begin
                o_core_valid[n] <= 1'b0;
                o_scan_done[n] <= 1'b0;
                // Data toggles between samples so a stale read shows
                o_core_data[n] <= ~o_core_data[n];
                if (i_core_halt[n]) begin
                    busy_q[n] <= 1'b0;
                end else if (i_scan_start[n]) begin
                    busy_q[n] <= 1'b1;
                    left_q[n] <= SAMPLES;
                end else if (busy_q[n] && i_conv_clock && !conv_q) begin
                    o_core_valid[n] <= 1'b1;
                    o_core_data[n] <= RESULT_W'(left_q[n] * 17 + n);
                    left_q[n] <= left_q[n] - 1;
                    if (left_q[n] == 1) begin
                        busy_q[n] <= 1'b0;
                        o_scan_done[n] <= 1'b1;
                    end
                end
            end
        end
    end
endmodule : converter_core_model

/* verification/testbench.sv */
// Self-checking bench for the converter clock and halt control block
`timescale 1ns/1ps
module testbench
    import adc_clock_pkg::*;
;
    typedef struct {
        logic [6:0] ctl;
        logic by_write;
        logic [1:0] trig;
        logic [1:0] want;
    } row_t;
    row_t rows [6];
    logic i_clock = 1'b0, i_rstn = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
    logic i_pwrite = 1'b0, i_osc_tick = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic [1:0] i_scan_sync_input = 2'b00;
    wire [1:0] i_scan_done, i_core_valid;
    wire [1:0][RESULT_W-1:0] i_core_data;
    wire [31:0] o_prdata;
    wire o_pready, o_pslverr, o_conv_clock, o_standby_current;
    wire [1:0] o_scan_start, o_core_halt, o_core_power, o_sample_valid;
    wire [1:0][RESULT_W-1:0] o_sample_data;
    int compares = 0, n_fail = 0, cycles = 0, smp_n = 0, ns, k;
    logic [1:0] ss;
    logic [31:0] rd;
    logic er, cl;
    logic [RESULT_W-1:0] smp_d;
    logic [2:0] ph = 3'h0;
    adc_clock_and_stop_control adc_clock_and_stop_control_inst (
        .i_clock, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr,
        .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_osc_tick,
        .i_scan_sync_input, .i_scan_done, .i_core_valid, .i_core_data,
        .o_conv_clock, .o_scan_start, .o_core_halt, .o_core_power,
        .o_standby_current, .o_sample_valid, .o_sample_data);
    converter_core_model converter_core_model_inst (.i_clock, .i_rstn,
        .i_conv_clock(o_conv_clock), .i_scan_start(o_scan_start),
        .i_core_halt(o_core_halt), .o_core_valid(i_core_valid),
        .o_core_data(i_core_data), .o_scan_done(i_scan_done));
    always #50 i_clock = ~i_clock;
    // Eight oscillator ticks per ten clocks
    always @(posedge i_clock) begin
        ph <= (ph == 3'h4) ? 3'h0 : ph + 3'h1;
        i_osc_tick <= (ph != 3'h4);
        if (o_sample_valid[0] === 1'b1) begin
            smp_n++;
            smp_d = o_sample_data[0];
        end
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        do @(posedge i_clock); while (o_pready !== 1'b1);
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clock);
    endtask : apb
    task automatic wait_clear(input logic [7:0] a, input int lsb);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while (rd[lsb +: 2] !== 2'b00 && n < 400);
        chk("busy bits", 32'h0, {30'h0, rd[lsb +: 2]});
    endtask : wait_clear
    task automatic pulse_sync(input logic [1:0] b);
        i_scan_sync_input <= b;
        @(posedge i_clock);
        i_scan_sync_input <= 2'b00;
    endtask : pulse_sync
    task automatic wait_start(input int lim);
        ns = 0;
        ss = 2'b00;
        while (ss == 2'b00 && ns < lim) begin
            @(posedge i_clock);
            ns++;
            ss = o_scan_start;
        end
    endtask : wait_start
    initial begin
        rows[0] = '{7'h00, 1'b0, 2'b01, 2'b11};
        rows[1] = '{7'h10, 1'b0, 2'b10, 2'b10};
        rows[2] = '{7'h50, 1'b0, 2'b01, 2'b11};
        rows[3] = '{7'h20, 1'b1, 2'b01, 2'b11};
        rows[4] = '{7'h30, 1'b1, 2'b10, 2'b10};
        rows[5] = '{7'h10, 1'b1, 2'b01, 2'b01};
        repeat (16) @(posedge i_clock);
        i_rstn <= 1'b1;
        // Period 60 clocks, about 166 kHz
        apb(1'b1, OFF_CONTROL2, 32'h9);
        apb(1'b1, OFF_POWER, 32'h20);
        wait_clear(OFF_POWER, PWR_STS_LSB);
        foreach (rows[i]) begin
            apb(1'b1, OFF_CONTROL1, {25'h0, rows[i].ctl});
            if (rows[i].by_write)
                apb(1'b1, OFF_CONTROL1,
                    {25'h0, rows[i].ctl | {3'h0, rows[i].trig, 2'b00}});
            else
                pulse_sync(rows[i].trig);
            wait_start(6);
            chk("start", {30'h0, rows[i].want}, {30'h0, ss});
            apb(1'b1, OFF_CONTROL1, {25'h0, rows[i].ctl | 7'h03});
            @(posedge i_clock);
            chk("halt", 32'h3, {30'h0, o_core_halt});
            wait_clear(OFF_STATUS, STS_BUSY_LSB);
            apb(1'b1, OFF_CONTROL1, {25'h0, rows[i].ctl});
        end
        pulse_sync(2'b10);
        wait_start(6);
        chk("first", 32'h2, {30'h0, ss});
        pulse_sync(2'b01);
        wait_start(66);
        chk("second", 32'h1, {30'h0, ss});
        wait_clear(OFF_STATUS, STS_BUSY_LSB);
        apb(1'b1, OFF_CONTROL1, 32'h11);
        pulse_sync(2'b01);
        wait_start(40);
        chk("halted sync", 32'h0, {30'h0, ss});
        apb(1'b1, OFF_CONTROL1, 32'h15);
        wait_start(40);
        chk("halted start", 32'h0, {30'h0, ss});
        k = smp_n;
        apb(1'b1, OFF_RESULT0, 32'hABC);
        @(posedge i_clock);
        chk("result pulses", k + 1, smp_n);
        chk("result data", 32'hABC, {20'h0, smp_d});
        apb(1'b1, OFF_CONTROL1, 32'h10);
        wait_start(40);
        chk("start on clear", 32'h0, {30'h0, ss});
        apb(1'b1, OFF_RESULT0, 32'h123);
        @(posedge i_clock);
        chk("result refused", k + 1, smp_n);
        apb(1'b1, OFF_POWER, 32'h28);
        k = 0;
        while (o_standby_current !== 1'b1 && k < 400) begin
            @(posedge i_clock);
            k++;
        end
        chk("standby", 32'h1, {31'h0, o_standby_current});
        pulse_sync(2'b01);
        wait_start(400);
        chk("late start", 32'h1, {30'h0, ss});
        chk("start delay", 32'h1, {31'h0, ns > 30});
        wait_clear(OFF_STATUS, STS_BUSY_LSB);
        apb(1'b1, OFF_POWER, 32'h20);
        k = 0;
        cl = 1'b1;
        repeat (240) begin
            @(posedge i_clock);
            k += int'(o_conv_clock === 1'b1 && cl === 1'b0);
            cl = o_conv_clock;
        end
        chk("normal source", 32'h3,
            {29'h0, o_standby_current, o_core_power});
        chk("running clock", 32'h1, {31'h0, k >= 3});
        apb(1'b1, OFF_POWER, 32'h2C);
        @(posedge i_clock);
        chk("apd", 32'h0,
            {29'h0, o_standby_current, o_core_power});
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_rstn <= 1'b1;
        apb(1'b0, OFF_POWER, 32'h0);
        chk("power reset", 32'({DELAY_RST, 2'b00, PWR_DOWN_RST}), rd);
        apb(1'b0, OFF_CONTROL2, 32'h0);
        chk("divisor reset", 32'(DIV_RST), rd);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        report_and_stop();
    end
endmodule : testbench
